// File: digitizer_status_word_low.sv
// Status word of the digitizer with fiber, setup and sync flags, AHB-Lite slave.
// Assumes single slave on the bus, hclk at 250 MHz, event inputs on hclk,
// and the system sync line arriving asynchronously from a pin.
`timescale 1ns/1ps
`include "status_word_map.svh"

module digitizer_status_word_low
  import status_word_pkg::*;
#(
  parameter int FERR_W = 8, // Fiber error detail width
  parameter int ACT_CYCLES = `ACT_WINDOW_MS * `CLK_KHZ, // Activity window in cycles
  parameter int BLK_MIN = 16 // Smallest block size
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic irq, // Level interrupt
  input wire logic [1:0] meas_state, // Measurement loop state
  input wire logic powerup_done, // Power-on sequence finished
  input wire logic fiber_rx_wr, // Word written to fiber receive FIFO
  input wire logic fiber_tx_rd, // Word taken from fiber transmit FIFO
  input wire logic [FERR_W-1:0] fiber_err_cond, // Fiber error conditions
  input wire logic [15:0] blk_max, // Largest block size now valid
  input wire logic [3:0] decim_max, // Largest decimation now valid
  input wire logic sync_assert, // User asserted sync
  input wire logic force_idle, // User forced idle
  input wire logic meas_cmd, // Measurement control command
  input wire logic sync_line_pin, // System sync line, high when released
  input wire logic adc_overrange, // Sample beyond ADC range
  output logic [15:0] block_size, // Block size in use
  output logic [3:0] decim // Decimation in use
);

  // Refuse settings the logic cannot serve
  if (FERR_W < 1 || FERR_W > 32) begin : g_chk_ferr
    $error("FERR_W out of range");
  end
  if (ACT_CYCLES < 1 || BLK_MIN < 1 || BLK_MIN > 65535) begin : g_chk_cnt
    $error("Count parameter out of range");
  end

  logic dph_reg; // Data phase pending
  logic dwr_reg; // Pending transfer is a write
  logic [7:0] dadr_reg; // Pending address
  logic ready_reg; // Power-on ready flag
  logic [31:0] act_cnt_reg; // Activity window counter
  logic fiber_fault_reg; // Fiber fault flag
  logic [FERR_W-1:0] ferr_det_reg; // Fiber error details
  logic setup_fault_reg; // Setup fault flag
  logic sync_done_reg; // Sync/idle done flag
  logic over_reg; // Overrange flag
  logic [3:0] irq_st_reg; // Sticky interrupt status
  logic [3:0] irq_mask_reg; // Interrupt mask
  logic [15:0] blk_req_reg; // Requested block size
  logic [3:0] dec_req_reg; // Requested decimation
  logic [2:0] sync_pipe_reg; // Sync line synchroniser
  logic sync_line; // Filtered sync line
  track_state_t trk_reg; // Propagation tracker
  logic fiber_fault_q_reg; // Previous fault, for edge
  logic sync_done_q_reg; // Previous done, for edge

  // Bus qualifiers
  logic wr_now; // Write carried out this cycle
  logic rd_now; // Read carried out this cycle
  logic [31:0] wdat; // Write data of the carried-out write
  logic cmd_fclr; // Fiber fault clear command
  logic cmd_sclr; // Setup fault clear command
  logic req_wr; // Parameter request written
  logic req_bad; // Written request invalid
  logic start_chg; // Sync or idle change started
  logic [15:0] status_word; // Assembled status word

  assign wr_now = dph_reg && !hreadyout && dwr_reg;
  assign rd_now = dph_reg && !hreadyout && !dwr_reg;
  assign wdat = hwdata;
  assign cmd_fclr = wr_now && dadr_reg == `OFF_COMMAND && wdat[`CMD_FIBER_CLR];
  assign cmd_sclr = wr_now && dadr_reg == `OFF_COMMAND && wdat[`CMD_SETUP_CLR];
  assign req_wr = wr_now && dadr_reg == `OFF_PARAM_REQ;
  assign start_chg = sync_assert || force_idle || meas_cmd;

  // Write is invalid if either field falls outside what related settings allow
  assign req_bad = (wdat[`PRM_BLK_LSB +: 16] < 16'(BLK_MIN))
    || (wdat[`PRM_BLK_LSB +: 16] > blk_max)
    || (wdat[`PRM_DEC_LSB +: 4] > decim_max);

  // Status word, upper bits that this block does not own read zero
  always_comb begin
    status_word = 16'h0000;
    status_word[`ST_MEAS_LSB +: 2] = meas_state;
    status_word[`ST_PASS] = 1'b1;
    status_word[`ST_READY] = ready_reg;
    status_word[`ST_FIBER_ACT] = act_cnt_reg != 32'h0;
    status_word[`ST_FIBER_FAULT] = fiber_fault_reg;
    status_word[`ST_SETUP_FAULT] = setup_fault_reg;
    status_word[`ST_SYNC_DONE] = sync_done_reg;
    status_word[`ST_OVERRANGE] = over_reg;
  end

  // Bus phases: one wait state on every transfer so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg <= 1'b0;
      dwr_reg <= 1'b0;
      dadr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (dph_reg && !hreadyout) begin // Wait state ends
      hreadyout <= 1'b1;
      dph_reg <= 1'b0;
    end else if (hsel && htrans[1] && hready) begin // Address phase taken
      dph_reg <= 1'b1;
      dwr_reg <= hwrite;
      dadr_reg <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  // Read data, unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_now) begin
      unique case (dadr_reg)
        `OFF_STATUS: hrdata <= {16'h0000, status_word};
        `OFF_FIBER_ERR: hrdata <= 32'(ferr_det_reg);
        `OFF_IRQ_STATUS: hrdata <= {28'h0, irq_st_reg};
        `OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask_reg};
        `OFF_PARAM_REQ: hrdata <= {12'h0, dec_req_reg, blk_req_reg};
        `OFF_PARAM_ACT: hrdata <= {12'h0, decim, block_size};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Power-on ready, latched once set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b0;
    end else if (powerup_done) begin
      ready_reg <= 1'b1;
    end
  end

  // Activity window: reload on traffic, run down to zero when quiet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_cnt_reg <= 32'h0;
    end else if (fiber_rx_wr || fiber_tx_rd) begin
      act_cnt_reg <= 32'(ACT_CYCLES);
    end else if (act_cnt_reg != 32'h0) begin
      act_cnt_reg <= act_cnt_reg - 32'h1;
    end
  end

  // Fiber fault: set wins over clear, status read has no effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fiber_fault_reg <= 1'b0;
      ferr_det_reg <= '0;
    end else if (|fiber_err_cond) begin
      fiber_fault_reg <= 1'b1;
      ferr_det_reg <= ferr_det_reg | fiber_err_cond;
    end else if (cmd_fclr) begin
      fiber_fault_reg <= 1'b0;
      ferr_det_reg <= '0;
    end
  end

  // Setup fault, set by a bad request, cleared by command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_fault_reg <= 1'b0;
    end else if (req_wr && req_bad) begin
      setup_fault_reg <= 1'b1;
    end else if (cmd_sclr) begin
      setup_fault_reg <= 1'b0;
    end
  end

  // Requested parameters, kept even when invalid so they apply later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_req_reg <= `RST_BLOCK;
      dec_req_reg <= `RST_DECIM;
    end else if (req_wr) begin
      blk_req_reg <= wdat[`PRM_BLK_LSB +: 16];
      dec_req_reg <= wdat[`PRM_DEC_LSB +: 4];
    end
  end

  // Block size in use: clamp to the nearest valid bound, re-checked every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_size <= `RST_BLOCK;
    end else if (blk_req_reg < 16'(BLK_MIN)) begin
      block_size <= 16'(BLK_MIN);
    end else if (blk_req_reg > blk_max) begin
      block_size <= blk_max;
    end else begin
      block_size <= blk_req_reg;
    end
  end

  // Decimation in use: hold the last valid value until the request fits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decim <= `RST_DECIM;
    end else if (dec_req_reg <= decim_max) begin
      decim <= dec_req_reg;
    end
  end

  // Sync line from a pin: three flops, change counts when last two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pipe_reg <= 3'h7; // Released level, so no false low follows reset
      sync_line <= 1'b1;
    end else begin
      sync_pipe_reg <= {sync_pipe_reg[1:0], sync_line_pin};
      if (sync_pipe_reg[2] == sync_pipe_reg[1]) begin
        sync_line <= sync_pipe_reg[2];
      end
    end
  end

  // Propagation tracker: a new change must see the line pulled low, then released,
  // so a stale released level cannot mark the new change done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trk_reg <= trk_done;
      sync_done_reg <= 1'b0;
    end else if (start_chg) begin
      trk_reg <= trk_wait_low;
      sync_done_reg <= 1'b0;
    end else begin
      unique case (trk_reg)
        trk_done: trk_reg <= trk_done;
        trk_wait_low: if (!sync_line) begin
          trk_reg <= trk_wait_high;
        end
        trk_wait_high: if (sync_line) begin
          trk_reg <= trk_done;
          sync_done_reg <= 1'b1;
        end
        default: trk_reg <= trk_done;
      endcase
    end
  end

  // Overrange: cleared by a status read, a new overrange wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      over_reg <= 1'b0;
    end else if (adc_overrange) begin
      over_reg <= 1'b1;
    end else if (rd_now && dadr_reg == `OFF_STATUS) begin
      over_reg <= 1'b0;
    end
  end

  // Edge detect for interrupt events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fiber_fault_q_reg <= 1'b0;
      sync_done_q_reg <= 1'b0;
    end else begin
      fiber_fault_q_reg <= fiber_fault_reg;
      sync_done_q_reg <= sync_done_reg;
    end
  end

  // Sticky interrupt status, read clears, new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (rd_now && dadr_reg == `OFF_IRQ_STATUS) begin
          irq_st_reg[i] <= 1'b0;
        end
      end
      if (fiber_fault_reg && !fiber_fault_q_reg) begin
        irq_st_reg[`IRQ_FIBER] <= 1'b1;
      end
      if (req_wr && req_bad) begin
        irq_st_reg[`IRQ_SETUP] <= 1'b1;
      end
      if (sync_done_reg && !sync_done_q_reg) begin
        irq_st_reg[`IRQ_SYNC] <= 1'b1;
      end
      if (adc_overrange) begin
        irq_st_reg[`IRQ_OVER] <= 1'b1;
      end
    end
  end

  // Mask register; status word, fiber error, interrupt status and parameters in use ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= `RST_MASK;
    end else if (wr_now && dadr_reg == `OFF_IRQ_MASK) begin
      irq_mask_reg <= wdat[3:0];
    end
  end

  // Interrupt output from a flop, one cycle behind the status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_reg & irq_mask_reg);
    end
  end

endmodule : digitizer_status_word_low

// File: status_word_map.svh
// Register offsets, field positions, reset values and timing counts of the status block.
// Assumes inclusion by the top module; definitions only.
`ifndef STATUS_WORD_MAP_SVH
`define STATUS_WORD_MAP_SVH

// Byte offsets on the register bus
`define OFF_STATUS 8'h00
`define OFF_FIBER_ERR 8'h04
`define OFF_COMMAND 8'h08
`define OFF_IRQ_STATUS 8'h0c
`define OFF_IRQ_MASK 8'h10
`define OFF_PARAM_REQ 8'h14
`define OFF_PARAM_ACT 8'h18

// Status word fields
`define ST_MEAS_LSB 0
`define ST_PASS 2
`define ST_READY 3
`define ST_FIBER_ACT 4
`define ST_FIBER_FAULT 5
`define ST_SETUP_FAULT 6
`define ST_SYNC_DONE 7
`define ST_OVERRANGE 12

// Command register bits (write one to act)
`define CMD_FIBER_CLR 0
`define CMD_SETUP_CLR 1

// Interrupt bits, same layout in status and mask
`define IRQ_FIBER 0
`define IRQ_SETUP 1
`define IRQ_SYNC 2
`define IRQ_OVER 3

// Parameter request layout: block size low half, decimation above
`define PRM_BLK_LSB 0
`define PRM_DEC_LSB 16

// Reset values
`define RST_BLOCK 16'h0400
`define RST_DECIM 4'h0
`define RST_MASK 4'h0

// Timing: activity window and clock rate
`define ACT_WINDOW_MS 500
`define CLK_KHZ 250000

`endif

// File: status_word_pkg.sv
// Types shared by the status block.
// Assumes status_word_map.svh holds the numeric constants.
package status_word_pkg;

  // Measurement loop state as reported in the low two bits
  typedef enum logic [1:0] {
    meas_state_waiting_arm = 2'h0,
    meas_state_idle = 2'h1,
    meas_state_running = 2'h2,
    meas_state_waiting_trigger = 2'h3
  } meas_state_t;

  // Sync/idle propagation tracker, one bit flips per step except trk_wait_high to trk_done
  typedef enum logic [1:0] {
    trk_done = 2'h0,
    trk_wait_low = 2'h1,
    trk_wait_high = 2'h3
  } track_state_t;

endpackage : status_word_pkg

// File: status_word_chk_sva.sv
// Checker for the digitizer status word block, watching top-level ports only.
// Assumes a single AHB-Lite master with hready fed back from hreadyout.
`timescale 1ns/1ps
module status_word_chk #(
  parameter int ACT_CYCLES = 50, // Activity window in cycles
  parameter int FERR_W = 8 // Fiber error width
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [1:0] meas_state, // Loop state in
  input wire logic fiber_rx_wr, // Receive traffic
  input wire logic fiber_tx_rd, // Transmit traffic
  input wire logic [FERR_W-1:0] fiber_err_cond, // Error conditions
  input wire logic adc_overrange // Overrange pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic take; // Address phase accepted
  logic rd0; // Status word read accepted
  int quiet; // Cycles since last fiber traffic
  assign take = hsel && htrans[1] && hready;
  assign rd0 = take && !hwrite && haddr == 8'h00;

  // Saturating quiet counter, so long idle runs cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet <= 0;
    else if (fiber_rx_wr || fiber_tx_rd) quiet <= 0;
    else if (quiet < ACT_CYCLES + 8) quiet <= quiet + 1;
  end

  okay_resp_a: assert property (hresp == 1'b0) else $error("error response seen");
  wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state shape wrong");
  meas_field_a: assert property (rd0 |-> ##2 hrdata[1:0] == $past(meas_state))
    else $error("loop state field wrong");
  pass_bit_a: assert property (rd0 |-> ##2 hrdata[2])
    else $error("pass bit low");
  fault_set_a: assert property (rd0 && fiber_err_cond != '0 |-> ##2 hrdata[5])
    else $error("fiber fault bit low");
  act_set_a: assert property ((fiber_rx_wr || fiber_tx_rd) ##2 rd0 |-> ##2 hrdata[4])
    else $error("activity bit low");
  act_clr_a: assert property (rd0 && quiet > ACT_CYCLES + 4 |-> ##2 !hrdata[4])
    else $error("activity bit stuck");
  over_set_a: assert property (adc_overrange && !rd0 ##2 rd0 |-> ##2 hrdata[12])
    else $error("overrange bit low");
  over_clr_a: assert property (rd0 && !adc_overrange ##1 !adc_overrange [*3] ##1
    rd0 && !adc_overrange |-> ##2 !hrdata[12]) else $error("overrange not cleared");
  unmapped_a: assert property (take && !hwrite && haddr == 8'h20 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read nonzero");

  cover property (rd0 ##2 hrdata[5]);
  cover property (rd0 ##2 hrdata[7]);
  cover property (rd0 ##2 hrdata[12]);
endmodule : status_word_chk

bind digitizer_status_word_low status_word_chk #(.ACT_CYCLES(ACT_CYCLES), .FERR_W(FERR_W))
  chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .meas_state(meas_state), .fiber_rx_wr(fiber_rx_wr), .fiber_tx_rd(fiber_tx_rd),
  .fiber_err_cond(fiber_err_cond), .adc_overrange(adc_overrange));

// File: ahb_host_model.sv
// Host controller model: single-word AHB-Lite master issuing status block accesses.
// Assumes it is the only master and hready is the slave's hreadyout.
`timescale 1ns/1ps
module ahb_host_model (
  input wire logic hclk, // Bus clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Slave select
  output logic [7:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write flag
  output logic [2:0] hsize, // Always a word
  output logic [31:0] hwdata // Write data
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; address held until accepted, data until done
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : ahb_host_model

// File: tb_digitizer_status_word_low.sv
// Self-checking bench for the digitizer status word block.
// Assumes the host model drives the bus; fiber, sync and limit inputs come from here.
`timescale 1ns/1ps
module tb_digitizer_status_word_low;
  import status_word_pkg::*;
  localparam int ACT = 50; // Shortened activity window
  typedef struct {logic [1:0] m; logic [31:0] e;} row_t;
  row_t rows [4] = '{'{2'h0, 32'h04}, '{2'h1, 32'h05}, '{2'h2, 32'h06}, '{2'h3, 32'h07}};
  logic hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic [1:0] meas_state = 2'h0;
  logic powerup_done = 1'b0, fiber_rx_wr = 1'b0, fiber_tx_rd = 1'b0, adc_overrange = 1'b0;
  logic sync_assert = 1'b0, force_idle = 1'b0, meas_cmd = 1'b0, sync_line_pin = 1'b1;
  logic [7:0] fiber_err_cond = 8'h00;
  logic [15:0] blk_max = 16'h0800, block_size;
  logic [3:0] decim_max = 4'h3, decim;
  int mismatches = 0, cmp_count = 0;

  always #2 hclk = ~hclk; // 250 MHz

  digitizer_status_word_low #(.ACT_CYCLES(ACT)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .meas_state(meas_state), .powerup_done(powerup_done),
    .fiber_rx_wr(fiber_rx_wr), .fiber_tx_rd(fiber_tx_rd), .fiber_err_cond(fiber_err_cond),
    .blk_max(blk_max), .decim_max(decim_max), .sync_assert(sync_assert),
    .force_idle(force_idle), .meas_cmd(meas_cmd), .sync_line_pin(sync_line_pin),
    .adc_overrange(adc_overrange), .block_size(block_size), .decim(decim));
  ahb_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Masked compare; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a);
    host_u.xfer(a, 1'b0, 32'h0, rv);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(a, 1'b1, d, rv);
  endtask : wr
  task automatic finish_test;
    $display("mismatches %0d of %0d compares", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk({block_size, 12'h0, decim}, 32'h0400_0000, '1); // Reset values of parameters in use
    chk({30'h0, irq, hresp}, 32'h0, '1);
    // Loop state rows, pass bit and flags in bits 3 to 7 clear after reset
    foreach (rows[i]) begin
      @(posedge hclk) meas_state <= rows[i].m;
      rd(8'h00);
      chk(rv, rows[i].e, 32'hff);
    end
    @(posedge hclk) powerup_done <= 1'b1;
    @(posedge hclk) powerup_done <= 1'b0;
    rd(8'h00);
    chk(rv, 32'h08, 32'h08);
    // Activity set, expiry, set again from transmit side
    @(posedge hclk) fiber_rx_wr <= 1'b1;
    @(posedge hclk) fiber_rx_wr <= 1'b0;
    rd(8'h00);
    chk(rv, 32'h10, 32'h10);
    repeat (ACT + 10) @(posedge hclk);
    rd(8'h00);
    chk(rv, 32'h00, 32'h10);
    @(posedge hclk) fiber_tx_rd <= 1'b1;
    @(posedge hclk) fiber_tx_rd <= 1'b0;
    rd(8'h00);
    chk(rv, 32'h10, 32'h10);
    // Fiber fault survives reads and a clear while present
    @(posedge hclk) fiber_err_cond <= 8'h05;
    rd(8'h00);
    rd(8'h00);
    chk(rv, 32'h20, 32'h20);
    wr(8'h08, 32'h1);
    rd(8'h00);
    chk(rv, 32'h20, 32'h20);
    @(posedge hclk) fiber_err_cond <= 8'h00;
    rd(8'h04);
    chk(rv, 32'h05, 32'hff);
    wr(8'h08, 32'h1);
    rd(8'h00);
    chk(rv, 32'h00, 32'h20);
    // Setup fault with interrupt unmasked, then clamp and hold-back of parameters
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h0000_0008);
    repeat (3) @(posedge hclk);
    chk({16'h0, block_size}, 32'h10, '1);
    chk({31'h0, irq}, 32'h1, '1);
    rd(8'h00);
    chk(rv, 32'h40, 32'h40);
    wr(8'h14, 32'h0005_0100);
    repeat (3) @(posedge hclk);
    chk({decim, block_size}, 32'h0_0100, 32'hf_ffff);
    @(posedge hclk) decim_max <= 4'h7;
    repeat (3) @(posedge hclk);
    chk({28'h0, decim}, 32'h5, '1);
    wr(8'h08, 32'h2);
    rd(8'h0c);
    chk(rv, 32'h2, 32'h2);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, '1);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0000_0008);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, '1);
    // Each kind of start, then sync line low and released
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk) {meas_cmd, force_idle, sync_assert} <= 3'b001 << k;
      @(posedge hclk) {meas_cmd, force_idle, sync_assert} <= 3'b000;
      rd(8'h00);
      chk(rv, 32'h00, 32'h80);
      @(posedge hclk) sync_line_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      sync_line_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      rd(8'h00);
      chk(rv, 32'h80, 32'h80);
    end
    // Overrange set, then cleared by the read itself
    @(posedge hclk) adc_overrange <= 1'b1;
    @(posedge hclk) adc_overrange <= 1'b0;
    rd(8'h00);
    chk(rv, 32'h1000, 32'h1000);
    rd(8'h00);
    chk(rv, 32'h0000, 32'h1000);
    // Write to the status word ignored; unmapped read
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00);
    chk(rv, 32'h0004, 32'hffff_ef04);
    rd(8'h20);
    chk(rv, 32'h0, '1);
    // Mid-run reset: parameters in use and flags return to reset values
    @(posedge hclk) adc_overrange <= 1'b1;
    @(posedge hclk) adc_overrange <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({block_size, 12'h0, decim}, 32'h0400_0000, '1);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00);
    chk(rv, 32'h0004, 32'h10fc);
    finish_test();
  end
endmodule : tb_digitizer_status_word_low
